// ==== src/bdo_icn.sv ====
// Purpose: interconnect end, snoop targeting and barrier completion
// Assumes: one master port, single-beat transfers, local word memory
// Notes: writes post early and commit after a fixed delay
`timescale 1ns/1ps
module bdo_icn import bdo_pkg::*; #(
	parameter int AW = 32,
	parameter int DW = 32,
	parameter int NM = 4,
	parameter int SELF = 0,
	parameter logic [NM-1:0] ISH_MASK = 4'h3,
	parameter logic [NM-1:0] OSH_MASK = 4'h7,
	parameter int MEM_WORDS = 256
) (
	input wire logic clk,
	input wire logic rst,
	bdo_if.icn bus,
	output logic snoop_valid,
	output logic [NM-1:0] snoop_mask,
	input wire logic snoop_done,
	input wire logic slave_idle,
	output logic alloc_valid,
	output logic bar_fwd_valid,
	output logic [1:0] bar_fwd_domain
);
	typedef enum logic [2:0] {I_IDLE, I_RSNP, I_RRSP, I_WDAT, I_WSNP, I_WRSP, I_RBAR, I_WBAR} bdo_icn_t;
	localparam int IDXW = $clog2(MEM_WORDS);
	localparam int CW = $clog2(COMMIT_CYC + 1);
	localparam logic [NM-1:0] SELF_BIT = NM'(1) << SELF;
	// ----------------------------------------------------------------
	// domain membership tables
	// ----------------------------------------------------------------
	// one table per port: symmetry relies on peers using the same table
	localparam logic [NM-1:0] ISH_SET = ISH_MASK | SELF_BIT;
	localparam logic [NM-1:0] OSH_SET = OSH_MASK | ISH_SET;
	localparam logic [NM-1:0] SYS_SET = {NM{1'b1}};
	bdo_icn_t state;
	logic [DW-1:0] mem [MEM_WORDS];
	logic [AW-1:0] addr;
	logic [1:0] dom;
	logic [1:0] bartype;
	logic [CW-1:0] post_cnt;
	logic rvalid;
	logic [DW-1:0] rdata;
	logic bvalid;
	logic ar_take;
	logic aw_take;
	logic bar_ok;
	logic in_range;
	logic [IDXW-1:0] idx;
	logic coherent;
	logic [NM-1:0] next_mask;
	logic [1:0] mask_dom;
	// ----------------------------------------------------------------
	// handshakes and decode
	// ----------------------------------------------------------------
	assign bus.arready = (state == I_IDLE);
	assign bus.awready = (state == I_IDLE) && !bus.arvalid;
	assign bus.wready = (state == I_WDAT);
	assign bus.rvalid = rvalid;
	assign bus.rdata = rdata;
	assign bus.rresp = RESP_OKAY;
	assign bus.bvalid = bvalid;
	assign bus.bresp = RESP_OKAY;
	assign ar_take = bus.arvalid && bus.arready;
	assign aw_take = bus.awvalid && bus.awready;
	assign idx = addr[IDXW+WORD_SHIFT-1:WORD_SHIFT];
	// no aliasing: addresses past the memory are dropped, not wrapped
	assign in_range = (addr >> (IDXW + WORD_SHIFT)) == '0;
	assign coherent = (dom == DOM_ISH) || (dom == DOM_OSH);
	assign mask_dom = (state == I_IDLE) ? bus.ardomain : dom; // reads snoop before dom loads
	always_comb begin
		next_mask = '0;
		unique case (mask_dom)
			DOM_NSH: next_mask = '0;
			DOM_ISH: next_mask = ISH_SET & ~SELF_BIT;
			DOM_OSH: next_mask = OSH_SET & ~SELF_BIT;
			DOM_SYS: next_mask = SYS_SET & ~SELF_BIT;
		endcase
	end
	// non-shareable orders against nobody; wider domains block on posted writes
	always_comb begin
		bar_ok = 1'b1;
		if (dom != DOM_NSH) begin
			bar_ok = (post_cnt == '0);
			if (bartype == BAR_SYNC && dom == DOM_SYS) begin
				bar_ok = (post_cnt == '0) && slave_idle;
			end
		end
	end
	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	// no checks on illegal sequences: such traffic has undefined results
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= I_IDLE;
		end else begin
			unique case (state)
				I_IDLE: begin
					if (ar_take) begin
						if (bus.arbar != BAR_NONE) begin
							state <= I_RBAR;
						end else if (bus.ardomain == DOM_ISH || bus.ardomain == DOM_OSH) begin
							state <= I_RSNP;
						end else begin
							state <= I_RRSP;
						end
					end else if (aw_take) begin
						state <= (bus.awbar != BAR_NONE) ? I_WBAR : I_WDAT;
					end
				end
				I_RSNP: begin
					if (snoop_done) begin
						state <= I_RRSP;
					end
				end
				I_RRSP: begin
					if (bus.rready) begin
						state <= I_IDLE;
					end
				end
				I_WDAT: begin
					if (bus.wvalid) begin
						state <= coherent ? I_WSNP : I_WRSP;
					end
				end
				I_WSNP: begin
					if (snoop_done) begin
						state <= I_WRSP;
					end
				end
				I_WRSP: begin
					if (bus.bready) begin
						state <= I_IDLE;
					end
				end
				I_RBAR: begin
					if (bar_ok) begin
						state <= I_RRSP;
					end
				end
				I_WBAR: begin
					if (bar_ok) begin
						state <= I_WRSP;
					end
				end
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			addr <= '0;
			dom <= DOM_NSH;
			bartype <= BAR_NONE;
		end else if (ar_take) begin
			addr <= bus.araddr;
			dom <= bus.ardomain;
			bartype <= bus.arbar;
		end else if (aw_take) begin
			addr <= bus.awaddr;
			dom <= bus.awdomain;
			bartype <= bus.awbar;
		end
	end
	// ----------------------------------------------------------------
	// responses and data
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid <= 1'b0;
			rdata <= '0;
		end else if (state == I_RRSP && bus.rready) begin
			rvalid <= 1'b0;
		end else if ((state == I_RBAR && bar_ok) || (state == I_RSNP && snoop_done) ||
				(state == I_IDLE && ar_take && bus.arbar == BAR_NONE &&
				bus.ardomain != DOM_ISH && bus.ardomain != DOM_OSH)) begin
			rvalid <= 1'b1;
			rdata <= '0;
		end
		if (!rst && state == I_RSNP && snoop_done && in_range) begin
			rdata <= mem[idx];
		end
	end
	// direct reads answer zero on the cycle after acceptance; only snooped reads load from memory
	always_ff @(posedge clk) begin
		if (rst) begin
			bvalid <= 1'b0;
		end else if (state == I_WRSP && bus.bready) begin
			bvalid <= 1'b0;
		end else if ((state == I_WBAR && bar_ok) || (state == I_WSNP && snoop_done) ||
				(state == I_WDAT && bus.wvalid && !coherent)) begin
			bvalid <= 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst && state == I_WDAT && bus.wvalid && in_range) begin
			mem[idx] <= bus.wdata;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			post_cnt <= '0;
		end else if (state == I_WDAT && bus.wvalid) begin
			post_cnt <= CW'(COMMIT_CYC);
		end else if (post_cnt != '0) begin
			post_cnt <= post_cnt - CW'(1);
		end
	end
	// ----------------------------------------------------------------
	// snoop, allocation and barrier forwarding
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			snoop_valid <= 1'b0;
			snoop_mask <= '0;
		end else begin
			snoop_valid <= 1'b0;
			if ((state == I_IDLE && ar_take && bus.arbar == BAR_NONE &&
					(bus.ardomain == DOM_ISH || bus.ardomain == DOM_OSH)) ||
					(state == I_WDAT && bus.wvalid && coherent)) begin
				snoop_valid <= 1'b1;
				snoop_mask <= next_mask;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			alloc_valid <= 1'b0;
		end else begin
			alloc_valid <= 1'b0;
			if (ar_take && bus.arbar == BAR_NONE && bus.ardomain != DOM_SYS) begin
				alloc_valid <= bus.arcache[CACHE_RA_BIT];
			end else if (aw_take && bus.awbar == BAR_NONE && bus.awdomain != DOM_SYS) begin
				alloc_valid <= bus.awcache[CACHE_WA_BIT];
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			bar_fwd_valid <= 1'b0;
			bar_fwd_domain <= DOM_NSH;
		end else begin
			bar_fwd_valid <= 1'b0;
			if ((state == I_RBAR || state == I_WBAR) && bar_ok && dom != DOM_NSH) begin
				bar_fwd_valid <= 1'b1;
				bar_fwd_domain <= dom;
			end
		end
	end
endmodule : bdo_icn

// ==== src/bdo_pkg.sv ====
// Purpose: shared constants for the barrier and domain ordering port
// Assumes: single clock, synchronous active-high reset
// Notes: domain and barrier codes are local encodings
package bdo_pkg;
	// ----------------------------------------------------------------
	// domain and barrier encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] DOM_NSH = 2'h0;
	localparam logic [1:0] DOM_ISH = 2'h1;
	localparam logic [1:0] DOM_OSH = 2'h2;
	localparam logic [1:0] DOM_SYS = 2'h3;
	localparam logic [1:0] BAR_NONE = 2'h0;
	localparam logic [1:0] BAR_MEM = 2'h1;
	localparam logic [1:0] BAR_SYNC = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	// ----------------------------------------------------------------
	// cache attribute bit positions
	// ----------------------------------------------------------------
	localparam int CACHE_MOD_BIT = 1;
	localparam int CACHE_RA_BIT = 2;
	localparam int CACHE_WA_BIT = 3;
	// ----------------------------------------------------------------
	// timing and geometry
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int COMMIT_NS = 20;
	localparam int COMMIT_CYC = (COMMIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int REGION_BYTES = 4096;
	localparam int WORD_SHIFT = 2;
endpackage : bdo_pkg

// ==== src/bdo_if.sv ====
// Purpose: link between coherent master port and interconnect
// Assumes: single-beat transfers, one clock
// Notes: no last signals, every burst is one beat
`timescale 1ns/1ps
interface bdo_if #(parameter int AW = 32, parameter int DW = 32);
	logic arvalid;
	logic arready;
	logic [AW-1:0] araddr;
	logic [1:0] ardomain;
	logic [1:0] arbar;
	logic [3:0] arcache;
	logic rvalid;
	logic rready;
	logic [DW-1:0] rdata;
	logic [1:0] rresp;
	logic awvalid;
	logic awready;
	logic [AW-1:0] awaddr;
	logic [1:0] awdomain;
	logic [1:0] awbar;
	logic [3:0] awcache;
	logic wvalid;
	logic wready;
	logic [DW-1:0] wdata;
	logic bvalid;
	logic bready;
	logic [1:0] bresp;
	modport master (
		output arvalid, araddr, ardomain, arbar, arcache, rready,
		output awvalid, awaddr, awdomain, awbar, awcache, wvalid, wdata, bready,
		input arready, rvalid, rdata, rresp, awready, wready, bvalid, bresp
	);
	modport icn (
		input arvalid, araddr, ardomain, arbar, arcache, rready,
		input awvalid, awaddr, awdomain, awbar, awcache, wvalid, wdata, bready,
		output arready, rvalid, rdata, rresp, awready, wready, bvalid, bresp
	);
endinterface : bdo_if

// ==== src/bdo_master.sv ====
// Purpose: coherent master end, tags domain and issues barrier pairs
// Assumes: one transaction in flight at a time
// Notes: barrier blocks all later traffic, the simplest safe ordering
`timescale 1ns/1ps
module bdo_master import bdo_pkg::*; #(
	parameter int AW = 32,
	parameter int DW = 32
) (
	input wire logic clk,
	input wire logic rst,
	bdo_if.master bus,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [AW-1:0] req_addr,
	input wire logic [DW-1:0] req_data,
	input wire logic [1:0] req_domain,
	input wire logic [1:0] req_barrier,
	input wire logic [3:0] req_cache,
	output logic rsp_valid,
	output logic rsp_write,
	output logic rsp_barrier,
	output logic [DW-1:0] rsp_data,
	output logic [1:0] rsp_resp
);
	typedef enum logic [2:0] {M_IDLE, M_RD, M_RWAIT, M_WR, M_BWAIT, M_BAR} bdo_mst_t;
	bdo_mst_t state;
	logic got_r;
	logic got_b;
	logic take;
	logic r_fire;
	logic b_fire;
	logic [AW-1:0] addr;
	logic [DW-1:0] data;
	logic [1:0] dom;
	logic [1:0] bar;
	logic [3:0] cache;
	logic ar_v;
	logic aw_v;
	logic w_v;
	// ----------------------------------------------------------------
	// handshakes
	// ----------------------------------------------------------------
	assign req_ready = (state == M_IDLE);
	assign take = req_valid && req_ready;
	assign bus.rready = (state == M_RWAIT) || (state == M_BAR && !got_r);
	assign bus.bready = (state == M_BWAIT) || (state == M_BAR && !got_b);
	assign r_fire = bus.rvalid && bus.rready;
	assign b_fire = bus.bvalid && bus.bready;
	// one register set feeds both halves so they never disagree
	assign bus.araddr = addr;
	assign bus.awaddr = addr;
	assign bus.ardomain = dom;
	assign bus.awdomain = dom;
	assign bus.arbar = bar;
	assign bus.awbar = bar;
	assign bus.arcache = cache;
	assign bus.awcache = cache;
	assign bus.wdata = data;
	assign bus.arvalid = ar_v;
	assign bus.awvalid = aw_v;
	assign bus.wvalid = w_v;
	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= M_IDLE;
		end else begin
			unique case (state)
				M_IDLE: begin
					if (take) begin
						if (req_barrier != BAR_NONE) begin
							state <= M_BAR;
						end else if (req_write) begin
							state <= M_WR;
						end else begin
							state <= M_RD;
						end
					end
				end
				M_RD: begin
					if (!ar_v || bus.arready) begin
						state <= M_RWAIT;
					end
				end
				M_RWAIT: begin
					if (r_fire) begin
						state <= M_IDLE;
					end
				end
				M_WR: begin
					if ((!aw_v || bus.awready) && (!w_v || bus.wready)) begin
						state <= M_BWAIT;
					end
				end
				M_BWAIT: begin
					if (b_fire) begin
						state <= M_IDLE;
					end
				end
				M_BAR: begin
					if ((got_r || r_fire) && (got_b || b_fire)) begin
						state <= M_IDLE;
					end
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// channel valids
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			ar_v <= 1'b0;
			aw_v <= 1'b0;
			w_v <= 1'b0;
		end else begin
			if (take) begin
				ar_v <= !req_write || (req_barrier != BAR_NONE);
				aw_v <= req_write || (req_barrier != BAR_NONE);
				w_v <= req_write && (req_barrier == BAR_NONE);
			end else begin
				if (bus.arready) begin
					ar_v <= 1'b0;
				end
				if (bus.awready) begin
					aw_v <= 1'b0;
				end
				if (bus.wready) begin
					w_v <= 1'b0;
				end
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			addr <= '0;
			data <= '0;
			dom <= DOM_NSH;
			bar <= BAR_NONE;
			cache <= 4'h0;
		end else if (take) begin
			addr <= req_addr;
			data <= req_data;
			dom <= req_domain;
			bar <= req_barrier;
			cache <= req_cache;
			if (req_domain == DOM_SYS) begin
				cache[CACHE_RA_BIT] <= 1'b0;
				cache[CACHE_WA_BIT] <= 1'b0;
			end
		end
	end
	// ----------------------------------------------------------------
	// barrier response tracking
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst || take) begin
			got_r <= 1'b0;
			got_b <= 1'b0;
		end else if (state == M_BAR) begin
			if (r_fire) begin
				got_r <= 1'b1;
			end
			if (b_fire) begin
				got_b <= 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_write <= 1'b0;
			rsp_barrier <= 1'b0;
			rsp_data <= '0;
			rsp_resp <= RESP_OKAY;
		end else begin
			rsp_valid <= 1'b0;
			if (state == M_RWAIT && r_fire) begin
				rsp_valid <= 1'b1;
				rsp_write <= 1'b0;
				rsp_barrier <= 1'b0;
				rsp_data <= bus.rdata;
				rsp_resp <= bus.rresp;
			end else if (state == M_BWAIT && b_fire) begin
				rsp_valid <= 1'b1;
				rsp_write <= 1'b1;
				rsp_barrier <= 1'b0;
				rsp_resp <= bus.bresp;
			end else if (state == M_BAR && (got_r || r_fire) && (got_b || b_fire)) begin
				rsp_valid <= 1'b1;
				rsp_write <= 1'b0;
				rsp_barrier <= 1'b1;
				rsp_resp <= RESP_OKAY;
			end
		end
	end
endmodule : bdo_master

// ==== verification/bdo_assertions.sv ====
// Purpose: concurrent checks on the master to interconnect link
// Assumes: one clock, synchronous active-high reset
// Notes: sees link signals only, no internals of either end
`timescale 1ns/1ps
module bdo_assertions import bdo_pkg::*; #(
	parameter int AW = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [AW-1:0] araddr,
	input wire logic [1:0] ardomain,
	input wire logic [1:0] arbar,
	input wire logic [3:0] arcache,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [AW-1:0] awaddr,
	input wire logic [1:0] awdomain,
	input wire logic [1:0] awbar,
	input wire logic [3:0] awcache,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready
);
	// --------
	// barrier tracking
	// --------
	logic bar_open;
	logic r_seen;
	logic b_seen;
	wire logic r_fire = rvalid && rready;
	wire logic b_fire = bvalid && bready;
	// separate flags: halves may answer in either order
	always_ff @(posedge clk) begin
		if (rst || !bar_open) begin
			r_seen <= 1'b0;
			b_seen <= 1'b0;
		end else begin
			r_seen <= r_seen || r_fire;
			b_seen <= b_seen || b_fire;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			bar_open <= 1'b0;
		end else if (!bar_open) begin
			bar_open <= arvalid && arbar != BAR_NONE;
		end else if ((r_seen || r_fire) && (b_seen || b_fire)) begin
			bar_open <= 1'b0;
		end
	end
	// --------
	// properties
	// --------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_bar_pair;
		(arvalid && arbar != BAR_NONE) |-> (awvalid && awbar == arbar && awdomain == ardomain && awaddr == araddr);
	endproperty
	a_bar_pair: assert property (p_bar_pair)
		else $error("barrier write half missing or unlike");
	property p_bar_nodata;
		(bar_open || (awvalid && awbar != BAR_NONE)) |-> !wvalid;
	endproperty
	a_bar_nodata: assert property (p_bar_nodata)
		else $error("data beat during barrier");
	property p_bar_hold;
		bar_open |-> !(arvalid && arbar == BAR_NONE) && !(awvalid && awbar == BAR_NONE);
	endproperty
	a_bar_hold: assert property (p_bar_hold)
		else $error("traffic passed an open barrier");
	property p_sys_nocache;
		((arvalid && ardomain == DOM_SYS) |-> arcache[3:2] == 2'h0) and
		((awvalid && awdomain == DOM_SYS) |-> awcache[3:2] == 2'h0);
	endproperty
	a_sys_nocache: assert property (p_sys_nocache)
		else $error("system domain request may allocate");
	property p_ar_stable;
		(arvalid && !arready) |=> arvalid && $stable(araddr) && $stable(ardomain) && $stable(arbar);
	endproperty
	a_ar_stable: assert property (p_ar_stable)
		else $error("read address changed while waiting");
	property p_aw_stable;
		(awvalid && !awready) |=> awvalid && $stable(awaddr) && $stable(awdomain) && $stable(awbar);
	endproperty
	a_aw_stable: assert property (p_aw_stable)
		else $error("write address changed while waiting");
	property p_aw_progress;
		awvalid |-> ##[0:300] awready;
	endproperty
	a_aw_progress: assert property (p_aw_progress)
		else $error("write address never taken");
	property p_r_progress;
		(arvalid && arready) |-> ##[1:300] r_fire;
	endproperty
	a_r_progress: assert property (p_r_progress)
		else $error("read answer missing");
	property p_b_progress;
		(awvalid && awready) |-> ##[1:300] b_fire;
	endproperty
	a_b_progress: assert property (p_b_progress)
		else $error("write answer missing");
	c_sync_sys: cover property (arvalid && arready && arbar == BAR_SYNC && ardomain == DOM_SYS);
	c_bar_b: cover property (bar_open && b_fire);
	c_wbeat: cover property (wvalid && wready);
endmodule : bdo_assertions

// ==== verification/test_barrier_domain_ordering.sv ====
// Purpose: self-checking bench for both ends of the link
// Assumes: 200 MHz clock, synchronous active-high reset
// Notes: table rows for plain traffic and barriers, then stalled barrier and reset
`timescale 1ns/1ps
module test_barrier_domain_ordering import bdo_pkg::*;;
	typedef struct packed {
		logic w;
		logic [31:0] a;
		logic [31:0] d;
		logic [1:0] dom;
		logic [1:0] bar;
		logic [3:0] cache;
		logic [31:0] exp_d;
		logic [3:0] exp_mask;
		logic exp_alloc;
	} bdo_row_t;
	localparam int N_ROWS = 15;
	// self is master 0, so it never shows in the masks
	localparam bdo_row_t ROWS [N_ROWS] = '{
		'{1'h1, 32'h10, 32'hA5A5, DOM_ISH, BAR_NONE, 4'hF, 32'h0, 4'h2, 1'h1},
		'{1'h0, 32'h10, 32'h0, DOM_ISH, BAR_NONE, 4'hF, 32'hA5A5, 4'h2, 1'h1},
		'{1'h1, 32'h20, 32'h5A5A, DOM_OSH, BAR_NONE, 4'h2, 32'h0, 4'h6, 1'h0},
		'{1'h0, 32'h20, 32'h0, DOM_OSH, BAR_NONE, 4'h0, 32'h5A5A, 4'h6, 1'h0},
		'{1'h1, 32'h30, 32'h1234, DOM_SYS, BAR_NONE, 4'hF, 32'h0, 4'h0, 1'h0},
		'{1'h0, 32'h30, 32'h0, DOM_SYS, BAR_NONE, 4'hF, 32'h0, 4'h0, 1'h0},
		'{1'h0, 32'h10, 32'h0, DOM_NSH, BAR_NONE, 4'h4, 32'h0, 4'h0, 1'h1},
		'{1'h1, 32'h24, 32'h9, DOM_NSH, BAR_NONE, 4'h8, 32'h0, 4'h0, 1'h1},
		'{1'h0, 32'h24, 32'h0, DOM_OSH, BAR_NONE, 4'h0, 32'h9, 4'h6, 1'h0},
		'{1'h1, 32'h400, 32'h77, DOM_ISH, BAR_NONE, 4'h0, 32'h0, 4'h2, 1'h0},
		'{1'h0, 32'h400, 32'h0, DOM_ISH, BAR_NONE, 4'h0, 32'h0, 4'h2, 1'h0},
		'{1'h0, 32'h0, 32'h0, DOM_ISH, BAR_MEM, 4'h0, 32'h0, 4'h0, 1'h0},
		'{1'h0, 32'h0, 32'h0, DOM_OSH, BAR_SYNC, 4'h0, 32'h0, 4'h0, 1'h0},
		'{1'h0, 32'h0, 32'h0, DOM_NSH, BAR_MEM, 4'h0, 32'h0, 4'h0, 1'h0},
		'{1'h0, 32'h0, 32'h0, DOM_SYS, BAR_MEM, 4'h0, 32'h0, 4'h0, 1'h0}
	};
	localparam bdo_row_t SYNC_SYS = '{1'h0, 32'h0, 32'h0, DOM_SYS, BAR_SYNC, 4'h0, 32'h0, 4'h0, 1'h0};
	logic clk, rst, req_valid, req_write, snoop_done, slave_idle;
	logic req_ready, rsp_valid, rsp_write, rsp_barrier, snoop_valid, alloc_valid, bar_fwd_valid;
	logic [31:0] req_addr, req_data, rsp_data;
	logic [1:0] req_domain, req_barrier, rsp_resp, bar_fwd_domain;
	logic [3:0] req_cache, snoop_mask, last_mask, ar_tag, aw_tag;
	logic [1:0] last_fwd;
	int n_mismatch, n_checks, n_snoop, n_alloc, n_fwd, n_rsp, n_ar, n_aw, n_w;
	bdo_if bus ();
	bdo_master bdo_master_i (.clk(clk), .rst(rst), .bus(bus), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_data(req_data),
		.req_domain(req_domain), .req_barrier(req_barrier), .req_cache(req_cache), .rsp_valid(rsp_valid),
		.rsp_write(rsp_write), .rsp_barrier(rsp_barrier), .rsp_data(rsp_data), .rsp_resp(rsp_resp));
	bdo_icn bdo_icn_i (
		.clk(clk), .rst(rst), .bus(bus), .snoop_valid(snoop_valid), .snoop_mask(snoop_mask),
		.snoop_done(snoop_done), .slave_idle(slave_idle), .alloc_valid(alloc_valid),
		.bar_fwd_valid(bar_fwd_valid), .bar_fwd_domain(bar_fwd_domain));
	bdo_assertions bdo_assertions_i (.clk(clk), .rst(rst), .arvalid(bus.arvalid),
		.arready(bus.arready), .araddr(bus.araddr), .ardomain(bus.ardomain), .arbar(bus.arbar),
		.arcache(bus.arcache), .rvalid(bus.rvalid), .rready(bus.rready), .awvalid(bus.awvalid),
		.awready(bus.awready), .awaddr(bus.awaddr), .awdomain(bus.awdomain), .awbar(bus.awbar),
		.awcache(bus.awcache), .wvalid(bus.wvalid), .wready(bus.wready), .bvalid(bus.bvalid),
		.bready(bus.bready));
	// --------
	// clock, snoop answers, monitor
	// --------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// snoops answered two cycles late, never on the request cycle
	initial begin
		forever begin
			@(posedge clk);
			#1;
			if (snoop_valid === 1'b1) begin
				repeat (2) @(posedge clk);
				#1 snoop_done = 1'b1;
				@(posedge clk);
				#1 snoop_done = 1'b0;
			end
		end
	end
	always @(posedge clk) begin
		if (snoop_valid === 1'b1) begin
			n_snoop++;
			last_mask = snoop_mask;
		end
		if (bar_fwd_valid === 1'b1) begin
			n_fwd++;
			last_fwd = bar_fwd_domain;
		end
		if (bus.arvalid === 1'b1 && bus.arready === 1'b1) begin
			n_ar++;
			ar_tag = {bus.ardomain, bus.arbar};
		end
		if (bus.awvalid === 1'b1 && bus.awready === 1'b1) begin
			n_aw++;
			aw_tag = {bus.awdomain, bus.awbar};
		end
		if (alloc_valid === 1'b1) n_alloc++;
		if (rsp_valid === 1'b1) n_rsp++;
		if (bus.wvalid === 1'b1 && bus.wready === 1'b1) n_w++;
	end
	// --------
	// tasks
	// --------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic issue(input bdo_row_t r);
		int k;
		req_valid = 1'b1;
		{req_write, req_addr, req_data, req_domain, req_barrier, req_cache} = {r.w, r.a, r.d, r.dom, r.bar, r.cache};
		k = 0;
		// ready is judged between edges, never in the edge that moves it
		while (req_ready !== 1'b1 && k < 50) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk("req_taken", 1, req_ready);
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		{n_snoop, n_alloc, n_fwd, n_rsp, n_ar, n_aw, n_w} = '0;
	endtask : issue
	task automatic wait_rsp(input bdo_row_t r);
		int k;
		k = 0;
		while (rsp_valid !== 1'b1 && k < 400) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk("rsp_valid", 1, rsp_valid);
		chk("rsp_barrier", r.bar != BAR_NONE, rsp_barrier);
		chk("rsp_write", r.w, rsp_write);
		chk("rsp_resp", RESP_OKAY, rsp_resp);
		if (!r.w) chk("rsp_data", r.exp_d, rsp_data);
		if (!r.w || r.bar != BAR_NONE) chk("ar_tag", {r.dom, r.bar}, ar_tag);
		if (r.w || r.bar != BAR_NONE) chk("aw_tag", {r.dom, r.bar}, aw_tag);
		if (r.bar != BAR_NONE) begin
			chk("ar_count", 1, n_ar);
			chk("aw_count", 1, n_aw);
			chk("w_count", 0, n_w);
			if (r.dom != DOM_NSH) chk("fwd_count", 2, n_fwd);
			if (r.dom != DOM_NSH) chk("fwd_domain", r.dom, last_fwd);
		end else begin
			chk("w_count", r.w, n_w);
			chk("snoop_count", r.exp_mask != 4'h0, n_snoop);
			if (r.exp_mask != 4'h0) chk("snoop_mask", r.exp_mask, last_mask);
			chk("alloc", r.exp_alloc, n_alloc);
		end
	endtask : wait_rsp
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	// --------
	// sequence
	// --------
	initial begin
		#100000;
		n_mismatch++;
		end_of_test;
	end
	initial begin
		{rst, req_valid, req_write, snoop_done, slave_idle} = 5'h11;
		{req_addr, req_data, req_domain, req_barrier, req_cache} = '0;
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		chk("req_ready", 1, req_ready);
		for (int i = 0; i < N_ROWS; i++) begin
			issue(ROWS[i]);
			wait_rsp(ROWS[i]);
		end
		// system sync barrier stalls on a busy downstream
		slave_idle = 1'b0;
		issue(SYNC_SYS);
		repeat (20) @(posedge clk);
		#1;
		chk("early_rsp", 0, n_rsp);
		chk("held_off", 0, req_ready);
		slave_idle = 1'b1;
		wait_rsp(SYNC_SYS);
		// reset lands mid-read
		issue(ROWS[1]);
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		chk("req_ready", 1, req_ready);
		chk("arvalid", 0, bus.arvalid);
		chk("rvalid", 0, bus.rvalid);
		repeat (4) @(posedge clk);
		#1;
		issue(ROWS[0]);
		wait_rsp(ROWS[0]);
		end_of_test;
	end
endmodule : test_barrier_domain_ordering
